// ==== src/framer_irq_pkg.sv ====
/*
  Package for the framer alarm and event interrupt block: register
  offsets, field positions, reset values and bus answer constants.
  Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
*/
`default_nettype none

package framer_irq_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] alarm_enable_off = 8'h00;
  localparam logic [7:0] event_status_off = 8'h04;
  localparam logic [7:0] event_enable_off = 8'h08;
  localparam logic [7:0] alarm_status_off = 8'h0c;
  localparam logic [7:0] live_state_off = 8'h10;
  localparam logic [7:0] mode_ctrl_off = 8'h14;

  // ==========================================================
  // Reset values
  localparam logic [7:0] alarm_enable_rst = 8'h00;
  localparam logic [7:0] event_status_rst = 8'h00;
  localparam logic [7:0] event_enable_rst = 8'h00;
  localparam logic [3:0] alarm_status_rst = 4'h0;
  localparam logic [1:0] mode_ctrl_rst = 2'h0;

  // ==========================================================
  // Alarm enable and alarm status field positions
  localparam int yellow_bit = 0;
  localparam int ais_bit = 1;
  localparam int red_bit = 2;
  localparam int bpv_bit = 3;
  localparam int alarm_count = 4;

  // ==========================================================
  // Event status field positions
  localparam int frm_err_bit = 0;
  localparam int sync_err_bit = 1;
  localparam int mimic_bit = 2;
  localparam int inframe_bit = 3;
  localparam int align_bit = 4;
  localparam int signal_bit = 5;
  localparam int national_bit = 6;
  localparam int cas_align_bit = 7;
  localparam int event_count = 8;

  // ==========================================================
  // Mode control fields
  localparam int e1_mode_bit = 0;
  localparam int read_clear_bit = 1;

  // Unmapped read answer
  localparam logic [31:0] unmapped_data = 32'h0000_0000;

endpackage : framer_irq_pkg

`default_nettype wire

// ==== src/sticky_flag.sv ====
/*
  One sticky status flag with set-over-clear priority.
  Assumes set and clear are synchronous single-cycle terms.
*/
`default_nettype none

module sticky_flag (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Control
  input wire logic set_in,
  input wire logic clear_in,
  // State
  output logic flag_out
);

  typedef struct packed {
    logic flag;
  } flag_state_type;

  flag_state_type state_reg;
  flag_state_type state_next;

  always_comb begin
    state_next = state_reg;
    if (set_in) begin
      state_next.flag = 1'b1;
    end else if (clear_in) begin
      state_next.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flag_out = state_reg.flag;

endmodule : sticky_flag

`default_nettype wire

// ==== src/framer_alarm_interrupt_status.sv ====
/*
  Per-channel receive framer interrupt logic: alarm enables, alarm
  status, framer event status with enables, and one level interrupt.
  Assumes detector strobes are synchronous one-cycle pulses on clk_in
  and the host is an Avalon-MM master honouring waitrequest.
*/
`default_nettype none

// Summary of operation
// - Bipolar violations interrupt only when enable bit 3
// - Frame loss interrupts only when enable bit 2
// - AIS changes interrupt only when enable bit 1
// - Yellow alarm changes interrupt only when bit 0
// - Status bit 7: CAS multiframe change, E1 only
// - Status bit 6: national bits changed, E1 only
// - Status bit 5: signaling information changed
// - Status bit 4: frame alignment changed
// - Status bit 3: in-frame state changed
// - Status bit 2: frame mimic state changed
// - Status bit 1: synchronization bit error
// - Status bit 0: framing error
// - Event enable bits gate status onto interrupt

module framer_alarm_interrupt_status
  import framer_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [1:0] avs_response_out,
  // Receive alarm detectors, one-cycle pulses
  input wire logic bpv_pulse_in,
  input wire logic receive_frame_loss_event_in,
  input wire logic ais_change_in,
  input wire logic yellow_change_in,
  // Framer event detectors, one-cycle pulses
  input wire logic cas_align_change_in,
  input wire logic national_change_in,
  input wire logic signal_change_in,
  input wire logic align_change_in,
  input wire logic inframe_change_in,
  input wire logic mimic_change_in,
  input wire logic sync_error_in,
  input wire logic framing_error_in,
  // Live framer levels
  input wire logic frame_loss_condition_in,
  input wire logic in_frame_in,
  // Interrupt
  output logic irq_out
);

  // ==========================================================
  // State
  typedef enum logic [1:0] {
    idle_st,
    answer_st
  } bus_state_type;

  typedef struct packed {
    bus_state_type bus;
    logic [7:0] alarm_enable;
    logic [7:0] event_enable;
    logic [1:0] mode_ctrl;
    logic [31:0] rdata;
    logic [1:0] resp;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic [event_count-1:0] event_status;
  logic [event_count-1:0] event_set;
  logic [event_count-1:0] event_clr;
  logic [alarm_count-1:0] alarm_status;
  logic [alarm_count-1:0] alarm_set;
  logic [alarm_count-1:0] alarm_clr;
  logic accept;
  logic e1_mode;

  // ==========================================================
  // Decode helpers
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr[7:2] == off[7:2]);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] addr);
    mapped = hit(addr, alarm_enable_off) || hit(addr, event_status_off)
      || hit(addr, event_enable_off) || hit(addr, alarm_status_off)
      || hit(addr, live_state_off) || hit(addr, mode_ctrl_off);
  endfunction : mapped

  assign accept = (avs_read_in || avs_write_in) &&
                  (state_reg.bus == idle_st);
  assign e1_mode = state_reg.mode_ctrl[e1_mode_bit];

  // ==========================================================
  // Event sources
  always_comb begin
    event_set = '0;
    event_set[cas_align_bit] = cas_align_change_in && e1_mode;
    event_set[national_bit] = national_change_in && e1_mode;
    event_set[signal_bit] = signal_change_in;
    event_set[align_bit] = align_change_in;
    event_set[inframe_bit] = inframe_change_in;
    event_set[mimic_bit] = mimic_change_in;
    event_set[sync_err_bit] = sync_error_in;
    event_set[frm_err_bit] = framing_error_in;
    alarm_set = '0;
    alarm_set[bpv_bit] = bpv_pulse_in;
    alarm_set[red_bit] = receive_frame_loss_event_in;
    alarm_set[ais_bit] = ais_change_in;
    alarm_set[yellow_bit] = yellow_change_in;
  end

  // ==========================================================
  // Clear terms: write one to clear, or clear on read when enabled
  always_comb begin
    event_clr = '0;
    alarm_clr = '0;
    if (accept && avs_write_in && avs_byteenable_in[0]) begin
      if (hit(avs_address_in, event_status_off)) begin
        event_clr = avs_writedata_in[event_count-1:0];
      end else if (hit(avs_address_in, alarm_status_off)) begin
        alarm_clr = avs_writedata_in[alarm_count-1:0];
      end
    end else if (accept && avs_read_in &&
                 state_reg.mode_ctrl[read_clear_bit]) begin
      if (hit(avs_address_in, event_status_off)) begin
        event_clr = '1;
      end else if (hit(avs_address_in, alarm_status_off)) begin
        alarm_clr = '1;
      end
    end
  end

  // ==========================================================
  // Sticky flags, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < event_count; gi++) begin : g_event
      sticky_flag u_flag (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .set_in(event_set[gi]),
        .clear_in(event_clr[gi]),
        .flag_out(event_status[gi])
      );
    end
    for (gi = 0; gi < alarm_count; gi++) begin : g_alarm
      sticky_flag u_flag (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .set_in(alarm_set[gi]),
        .clear_in(alarm_clr[gi]),
        .flag_out(alarm_status[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Bus slave and register writes
  always_comb begin
    state_next = state_reg;
    case (state_reg.bus)
      idle_st: begin
        if (accept) begin
          state_next.bus = answer_st;
          state_next.resp = mapped(avs_address_in) ? 2'h0 : 2'h2;
          state_next.rdata = unmapped_data;
          if (avs_read_in) begin
            if (hit(avs_address_in, alarm_enable_off)) begin
              state_next.rdata = {24'h0, state_reg.alarm_enable};
            end else if (hit(avs_address_in, event_status_off)) begin
              state_next.rdata = {24'h0, event_status};
            end else if (hit(avs_address_in, event_enable_off)) begin
              state_next.rdata = {24'h0, state_reg.event_enable};
            end else if (hit(avs_address_in, alarm_status_off)) begin
              state_next.rdata = {28'h0, alarm_status};
            end else if (hit(avs_address_in, live_state_off)) begin
              state_next.rdata = {30'h0, in_frame_in,
                                  frame_loss_condition_in};
            end else if (hit(avs_address_in, mode_ctrl_off)) begin
              state_next.rdata = {30'h0, state_reg.mode_ctrl};
            end
          end else if (avs_byteenable_in[0]) begin
            if (hit(avs_address_in, alarm_enable_off)) begin
              state_next.alarm_enable = avs_writedata_in[7:0];
            end else if (hit(avs_address_in, event_enable_off)) begin
              state_next.event_enable = avs_writedata_in[7:0];
            end else if (hit(avs_address_in, mode_ctrl_off)) begin
              state_next.mode_ctrl = avs_writedata_in[1:0];
            end
          end
        end
      end
      answer_st: begin
        state_next.bus = idle_st;
      end
      default: begin
        state_next.bus = idle_st;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state_reg.bus <= idle_st;
      state_reg.alarm_enable <= alarm_enable_rst;
      state_reg.event_enable <= event_enable_rst;
      state_reg.mode_ctrl <= mode_ctrl_rst;
      state_reg.rdata <= '0;
      state_reg.resp <= 2'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Waitrequest high until the answer cycle
  assign avs_waitrequest_out = (state_reg.bus != answer_st);
  assign avs_readdata_out = state_reg.rdata;
  assign avs_response_out = state_reg.resp;

  // ==========================================================
  // Interrupt
  logic alarm_irq;
  logic event_irq;
  always_comb begin
    alarm_irq = 1'b0;
    alarm_irq = alarm_irq ||
      (alarm_status[bpv_bit] && state_reg.alarm_enable[bpv_bit]);
    alarm_irq = alarm_irq ||
      (alarm_status[red_bit] && state_reg.alarm_enable[red_bit]);
    alarm_irq = alarm_irq ||
      (alarm_status[ais_bit] && state_reg.alarm_enable[ais_bit]);
    alarm_irq = alarm_irq || (alarm_status[yellow_bit] &&
      state_reg.alarm_enable[yellow_bit]);
    event_irq = |(event_status & state_reg.event_enable);
  end

  assign irq_out = alarm_irq || event_irq;

endmodule : framer_alarm_interrupt_status

`default_nettype wire

// ==== verification/framer_detector_model.sv ====
/*
  Receive framer detector model: one-cycle detector pulses on request,
  and the live frame loss and in-frame levels.
  Assumes the bench holds each pulse request for one cycle.
*/
`default_nettype none

module framer_detector_model (
  // Clock
  input wire logic clk_in,
  // Bench requests
  input wire logic [11:0] fire_in,
  input wire logic [1:0] level_in,
  // Detector outputs
  output logic [11:0] pulse_out,
  output logic loss_out,
  output logic in_frame_out
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk_in) begin
    pulse_out <= fire_in;
    loss_out <= level_in[0];
    in_frame_out <= level_in[1];
  end
endmodule : framer_detector_model

`default_nettype wire

// ==== verification/framer_irq_monitor.sv ====
/*
  Checker on the interrupt block ports.
  Assumes one clock and synchronous active-low reset.
*/
`default_nettype none

module framer_irq_monitor (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic [1:0] avs_response_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  // ==========================================
  // Sequences
  sequence s_taken;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_rd_bad;
    avs_read_in && avs_waitrequest_out && avs_address_in >= 8'h18;
  endsequence
  sequence s_rd_ok;
    avs_read_in && avs_waitrequest_out && avs_address_in < 8'h18;
  endsequence
  // ==========================================
  // Properties
  property p_answer;
    s_taken |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
  endproperty
  property p_idle;
    !(avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> avs_waitrequest_out;
  endproperty
  property p_stand;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  property p_bad_resp;
    s_rd_bad |=> avs_response_out == 2'b10;
  endproperty
  property p_bad_data;
    s_rd_bad |=> avs_readdata_out == 32'h0000_0000;
  endproperty
  property p_ok_resp;
    s_rd_ok |=> avs_response_out == 2'b00;
  endproperty
  property p_reset;
    $rose(rstn_in) |-> avs_waitrequest_out && !irq_out
      && avs_readdata_out == 32'h0000_0000;
  endproperty
  property p_sticky;
    irq_out && !avs_read_in && !avs_write_in |=> irq_out;
  endproperty
  a_answer : assert property (p_answer) else $error("no answer");
  a_idle : assert property (p_idle) else $error("answer unasked");
  a_stand : assert property (p_stand) else $error("answer too long");
  a_bad_resp : assert property (p_bad_resp) else $error("bad resp");
  a_bad_data : assert property (p_bad_data) else $error("bad data");
  a_ok_resp : assert property (p_ok_resp) else $error("ok resp");
  a_reset : assert property (p_reset) else $error("reset");
  a_sticky : assert property (p_sticky) else $error("irq");
endmodule : framer_irq_monitor

bind framer_alarm_interrupt_status framer_irq_monitor i_mon (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .avs_response_out(avs_response_out),
  .irq_out(irq_out)
);

`default_nettype wire

// ==== verification/test_framer_alarm_interrupt_status.sv ====
/*
  Self-checking bench for the framer interrupt block.
  Assumes the detector model and the bound checker.
*/
`default_nettype none

module test_framer_alarm_interrupt_status;
  import framer_irq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rv;
  logic [1:0] rsp;
  logic [1:0] rr;
  logic wreq;
  logic irq;
  logic loss;
  logic infr;
  logic [11:0] fire = 12'h000;
  logic [11:0] pls;
  logic [1:0] lvl = 2'b10;
  logic [3:0] be = 4'h1;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;

  framer_detector_model i_framer_detector_model (.clk_in(clk_in),
    .fire_in(fire), .level_in(lvl), .pulse_out(pls), .loss_out(loss),
    .in_frame_out(infr));

  framer_alarm_interrupt_status i_framer_alarm_interrupt_status (
    .clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .avs_response_out(rsp),
    .bpv_pulse_in(pls[11]), .receive_frame_loss_event_in(pls[10]),
    .ais_change_in(pls[9]), .yellow_change_in(pls[8]),
    .cas_align_change_in(pls[7]), .national_change_in(pls[6]),
    .signal_change_in(pls[5]), .align_change_in(pls[4]),
    .inframe_change_in(pls[3]), .mimic_change_in(pls[2]),
    .sync_error_in(pls[1]), .framing_error_in(pls[0]),
    .frame_loss_condition_in(loss), .in_frame_in(infr), .irq_out(irq));

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  // ==========================================
  // Shared tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk_in); while (wreq !== 1'b0);
    rv = rdat;
    rr = rsp;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask : rchk

  task automatic pulse(input logic [11:0] v);
    @(posedge clk_in);
    fire <= v;
    @(posedge clk_in);
    fire <= 12'h000;
    repeat (2) @(posedge clk_in);
  endtask : pulse

  // ==========================================
  // Scenarios
  task automatic test_reset;
    rchk(alarm_enable_off, 32'h0);
    rchk(event_status_off, 32'h0);
    rchk(event_enable_off, 32'h0);
    rchk(alarm_status_off, 32'h0);
    rchk(live_state_off, 32'h2);
    chk(32'(irq), 32'h0);
  endtask : test_reset

  task automatic test_registers;
    bus(1'b1, alarm_enable_off, 32'h5a);
    bus(1'b1, event_enable_off, 32'ha5);
    bus(1'b1, mode_ctrl_off, 32'h3);
    rchk(alarm_enable_off, 32'h5a);
    rchk(event_enable_off, 32'ha5);
    rchk(mode_ctrl_off, 32'h3);
    chk(32'(rr), 32'h0);
    be <= 4'h2;
    bus(1'b1, alarm_enable_off, 32'h00);
    be <= 4'h1;
    rchk(alarm_enable_off, 32'h5a);
    lvl <= 2'b01;
    rchk(live_state_off, 32'h1);
    lvl <= 2'b10;
    bus(1'b1, alarm_enable_off, 32'h0);
    bus(1'b1, event_enable_off, 32'h0);
    bus(1'b1, mode_ctrl_off, 32'h0);
  endtask : test_registers

  task automatic test_events;
    bus(1'b1, mode_ctrl_off, 32'h1);
    for (int i = 0; i < 8; i++) begin
      pulse(12'h001 << i);
      rchk(event_status_off, 32'h1 << i); // to
      bus(1'b1, event_status_off, 32'h1 << i);
      rchk(event_status_off, 32'h0);
    end
    bus(1'b1, mode_ctrl_off, 32'h0);
    pulse(12'h0c0);
    rchk(event_status_off, 32'h0);
  endtask : test_events

  task automatic test_event_irq;
    bus(1'b1, event_enable_off, 32'h1);
    pulse(12'h001);
    chk(32'(irq), 32'h1);
    bus(1'b1, mode_ctrl_off, 32'h2);
    rchk(event_status_off, 32'h1);
    rchk(event_status_off, 32'h0);
    chk(32'(irq), 32'h0);
    bus(1'b1, event_enable_off, 32'h0);
    pulse(12'h001);
    chk(32'(irq), 32'h0);
    rchk(event_status_off, 32'h1);
    bus(1'b1, mode_ctrl_off, 32'h0);
  endtask : test_event_irq

  task automatic test_alarms;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, alarm_enable_off, 32'h1 << i);
      pulse(12'h100 << i);
      chk(32'(irq), 32'h1);
      rchk(alarm_status_off, 32'h1 << i);
      bus(1'b1, alarm_status_off, 32'h1 << i);
      chk(32'(irq), 32'h0);
      bus(1'b1, alarm_enable_off, 32'h0);
      pulse(12'h100 << i);
      chk(32'(irq), 32'h0);
      bus(1'b1, alarm_status_off, 32'h1 << i);
    end
  endtask : test_alarms

  task automatic test_mid_reset;
    bus(1'b1, event_enable_off, 32'hff);
    pulse(12'hfff);
    chk(32'(irq), 32'h1);
    rchk(event_status_off, 32'h3f);
    rchk(alarm_status_off, 32'hf);
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    chk(32'(irq), 32'h0);
    rchk(event_status_off, 32'h0);
    rchk(alarm_status_off, 32'h0);
    rchk(event_enable_off, 32'h0);
  endtask : test_mid_reset

  task automatic test_unmapped;
    bus(1'b1, 8'h18, 32'hff);
    rchk(8'h18, 32'h0);
    chk(32'(rr), 32'h2);
    rchk(alarm_enable_off, 32'h0);
  endtask : test_unmapped

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    test_reset();
    test_registers();
    test_events();
    test_event_irq();
    test_alarms();
    test_unmapped();
    test_mid_reset();
    finish_test();
  end
endmodule : test_framer_alarm_interrupt_status

`default_nettype wire
